// ===== src/cc_pkg.sv
/*
  package for the clock-controller configuration block: register offsets,
  field positions, reset values, timing constants and the carrier structs.
  assumes a single 25 MHz system clock shared by every user of it.
*/
`default_nettype none

package cc_pkg;

  // register offsets (byte addresses on the 8-bit register port)
  localparam logic [7:0] OFS_MAIN_CLOCK_STATUS = 8'h05;
  localparam logic [7:0] OFS_HF_OSC_CONTROL = 8'h08;
  localparam logic [7:0] OFS_HF_OSC_TRIM = 8'h09;
  localparam logic [7:0] OFS_PLL_CONTROL = 8'h10;
  localparam logic [7:0] OFS_LF_OSC_CONTROL = 8'h18;

  // reset values
  localparam logic [7:0] RST_HF_OSC_CONTROL = 8'h0C;
  localparam logic [7:0] RST_HF_OSC_TRIM = 8'h00;
  localparam logic [7:0] RST_PLL_CONTROL = 8'h00;
  localparam logic [7:0] RST_LF_OSC_CONTROL = 8'h00;

  // field positions
  localparam int unsigned POS_RUN_IN_STANDBY = 7;
  localparam int unsigned POS_PLL_SOURCE = 6;
  localparam int unsigned POS_FREQ_LSB = 2;
  localparam int unsigned POS_TRIM_ENABLE = 0;
  localparam int unsigned POS_MULT_LSB = 0;
  localparam int unsigned POS_TRIM_SIGN = 5;

  // status bit positions in the main clock status register
  localparam int unsigned POS_ST_SWITCHING = 0;
  localparam int unsigned POS_ST_INT_HF = 1;
  localparam int unsigned POS_ST_INT_LF = 2;
  localparam int unsigned POS_ST_EXT_LF = 3;
  localparam int unsigned POS_ST_EXT_HF = 4;
  localparam int unsigned POS_ST_PLL = 5;

  // special field codes
  localparam logic [3:0] FREQ_4MHZ = 4'h3;
  localparam logic [3:0] FREQ_GAP = 4'h4;
  localparam logic [3:0] FREQ_MAX = 4'h9;
  localparam logic [1:0] MULT_OFF = 2'h0;
  localparam logic [1:0] MULT_RESERVED = 2'h3;

  // timing: clock period and documented figures
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned TRIM_UPDATE_NS = 3000;  // longest time, rounds down
  localparam int unsigned TRIM_UPDATE_EXTRA = 3;
  localparam int unsigned TRIM_UPDATE_CYC = TRIM_UPDATE_NS / CLK_PERIOD_NS + TRIM_UPDATE_EXTRA;
  // availability after a request, in oscillator cycles at the slowest setting
  localparam int unsigned HF_AVAIL_NS = 2 * 1000;    // two cycles at 1 MHz
  localparam int unsigned PLL_AVAIL_NS = 2 * 500;    // two cycles at 2 MHz
  localparam int unsigned LF_AVAIL_NS = 4 * 30518;   // four cycles at 32.768 kHz
  localparam int unsigned HF_AVAIL_CYC = (HF_AVAIL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PLL_AVAIL_CYC = (PLL_AVAIL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LF_AVAIL_CYC = (LF_AVAIL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // main clock source codes
  typedef enum logic [1:0] {
    SRC_INT_HF = 2'b00,
    SRC_INT_LF = 2'b01,
    SRC_EXT_LF = 2'b10,
    SRC_EXT_HF = 2'b11
  } cc_src_t;

  // sleep modes
  typedef enum logic [1:0] {
    MODE_ACTIVE = 2'b00,
    MODE_IDLE = 2'b01,
    MODE_STANDBY = 2'b10,
    MODE_POWER_DOWN = 2'b11
  } cc_mode_t;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cc_bus_req_t;

  // raw analog readiness levels, asynchronous to clk
  typedef struct packed {
    logic ext_hf_crystal_stable;
    logic ext_hf_clock_running;
    logic ext_lf_crystal_stable;
    logic ext_lf_clock_running;
    logic int_lf_stable;
    logic int_hf_stable;
    logic pll_running;
  } cc_osc_raw_t;

  // clock requests from on-chip users, on clk
  typedef struct packed {
    logic hf;
    logic pll;
    logic lf;
  } cc_req_t;

endpackage : cc_pkg

`default_nettype wire

// ===== src/cc_clock_config.sv
/*
  clock-controller configuration and status: oscillator and pll control
  registers, trim register, main clock status and main clock switching.
  assumes requests, unlock and sleep mode come from logic on clk, while
  oscillator readiness levels arrive asynchronously and are synchronised.
*/
// How it works
// - ext hf status: stable or running by select
// - ext lf status: stable or running by select
// - int lf stable shown as read-only bit
// - int hf stable shown as read-only bit
// - switching flag; switch only when target stable
// - hf run-in-standby keeps oscillator running
// - hf output delivered on request, two cycles later
// - hf requester waits for start-up first
// - frequency select codes, reserved ignored, default 4 MHz
// - auto-tune enable steers crystal tuning
// - trim is signed six-bit, -32 to +31
// - top trim bits ignore writes, mirror bit 5
// - trim locked while auto-tune on
// - trim loads tuner result after disable delay
// - pll run-in-standby keeps pll running
// - pll output on request, two cycles later
// - pll source select: internal or external hf
// - multiplier: off, x2, x3, reserved ignored
// - lf run-in-standby runs in all modes
`default_nettype none

module cc_clock_config #(
  parameter int unsigned LF_AVAIL_CYCLES = cc_pkg::LF_AVAIL_CYC
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  // register port
  input wire cc_pkg::cc_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  // configuration change unlock, level on clk
  input wire logic ccp_unlocked,
  // sources selects held in neighbouring registers
  input wire logic ext_hf_source_select,
  input wire logic ext_lf_source_select,
  // oscillator readiness, asynchronous
  input wire cc_pkg::cc_osc_raw_t osc_raw,
  // sleep mode and clock requests
  input wire cc_pkg::cc_mode_t sleep_mode,
  input wire cc_pkg::cc_req_t clk_req,
  // main clock switch request
  input wire logic mclk_switch_req,
  input wire cc_pkg::cc_src_t mclk_switch_src,
  // latest result from the crystal tuner
  input wire logic [5:0] tuner_result,
  // oscillator controls
  output logic hf_osc_run,
  output logic hf_clk_available,
  output logic [3:0] hf_frequency_select,
  output logic crystal_trim_enable,
  output logic [5:0] hf_trim,
  output logic pll_run,
  output logic pll_clk_available,
  output logic pll_source,
  output logic [1:0] pll_multiplier,
  output logic lf_osc_run,
  output logic lf_clk_available,
  // main clock source in use
  output cc_pkg::cc_src_t mclk_source,
  output logic main_clock_switching
);

  // frequency select code valid check
  function automatic logic freq_code_ok(input logic [3:0] code);
    freq_code_ok = (code <= cc_pkg::FREQ_MAX) && (code != cc_pkg::FREQ_GAP);
  endfunction

  // run decision for a standby-capable oscillator
  function automatic logic keep_running(input logic rsb, input cc_pkg::cc_mode_t mode,
                                        input logic all_modes, input logic req);
    keep_running = req || (rsb && (all_modes || mode != cc_pkg::MODE_POWER_DOWN));
  endfunction

  // register state
  logic hf_rsb_q;  // hf run-in-standby
  logic [3:0] freq_q;  // hf frequency select
  logic tune_en_q;  // auto-tune enable
  logic [5:0] trim_q;  // signed trim value
  logic pll_rsb_q;  // pll run-in-standby
  logic pll_src_q;  // pll source select
  logic [1:0] mult_q;  // pll multiplier
  logic lf_rsb_q;  // lf run-in-standby
  logic [7:0] rdata_q;  // read data register

  // synchroniser stages for the readiness levels
  cc_pkg::cc_osc_raw_t sync1_q;  // first stage, read only by sync2_q
  cc_pkg::cc_osc_raw_t sync2_q;  // safe to use

  // decoded status
  logic ext_hf_status;
  logic ext_lf_status;
  logic [7:0] status_byte;

  // write decode
  logic wr_hf_ctrl;
  logic wr_trim;
  logic wr_pll_ctrl;
  logic wr_lf_ctrl;

  // trim reload after auto-tune is turned off
  logic [7:0] reload_cnt_q;
  logic reload_busy_q;

  // main clock switching
  logic switching_q;
  cc_pkg::cc_src_t target_q;
  cc_pkg::cc_src_t mclk_q;
  logic target_stable;

  // availability counters and output flops
  logic [7:0] hf_cnt_q;
  logic [7:0] pll_cnt_q;
  logic [15:0] lf_cnt_q;
  logic hf_run_q;
  logic pll_run_q;
  logic lf_run_q;
  logic hf_avail_q;
  logic pll_avail_q;
  logic lf_avail_q;

  // two-flop synchroniser, frozen with the rest while clk_en is low
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (clk_en) begin
      sync1_q <= osc_raw;
      sync2_q <= sync1_q;
    end
  end

  // status meaning follows the source select of each external source
  assign ext_hf_status = ext_hf_source_select ? sync2_q.ext_hf_clock_running
                                              : sync2_q.ext_hf_crystal_stable;
  assign ext_lf_status = ext_lf_source_select ? sync2_q.ext_lf_clock_running
                                              : sync2_q.ext_lf_crystal_stable;

  // status byte, bits above the pll flag read zero
  always_comb begin
    status_byte = 8'h00;
    status_byte[cc_pkg::POS_ST_SWITCHING] = switching_q;
    status_byte[cc_pkg::POS_ST_INT_HF] = sync2_q.int_hf_stable;
    status_byte[cc_pkg::POS_ST_INT_LF] = sync2_q.int_lf_stable;
    status_byte[cc_pkg::POS_ST_EXT_LF] = ext_lf_status;
    status_byte[cc_pkg::POS_ST_EXT_HF] = ext_hf_status;
    status_byte[cc_pkg::POS_ST_PLL] = sync2_q.pll_running;
  end

  // protected writes are dropped unless the unlock is open this cycle
  assign wr_hf_ctrl = bus_req.wr && ccp_unlocked &&
                      bus_req.addr == cc_pkg::OFS_HF_OSC_CONTROL;
  assign wr_pll_ctrl = bus_req.wr && ccp_unlocked &&
                       bus_req.addr == cc_pkg::OFS_PLL_CONTROL;
  assign wr_lf_ctrl = bus_req.wr && ccp_unlocked &&
                      bus_req.addr == cc_pkg::OFS_LF_OSC_CONTROL;
  // trim register carries no protection, but is locked by auto-tune
  assign wr_trim = bus_req.wr && bus_req.addr == cc_pkg::OFS_HF_OSC_TRIM &&
                   !tune_en_q && !reload_busy_q;

  // hf oscillator control register
  always_ff @(posedge clk) begin
    if (rst) begin
      hf_rsb_q <= cc_pkg::RST_HF_OSC_CONTROL[cc_pkg::POS_RUN_IN_STANDBY];
      freq_q <= cc_pkg::RST_HF_OSC_CONTROL[cc_pkg::POS_FREQ_LSB +: 4];
      tune_en_q <= cc_pkg::RST_HF_OSC_CONTROL[cc_pkg::POS_TRIM_ENABLE];
    end else if (clk_en && wr_hf_ctrl) begin
      hf_rsb_q <= bus_req.wdata[cc_pkg::POS_RUN_IN_STANDBY];
      // reserved codes would give an undefined frequency: keep the old one
      if (freq_code_ok(bus_req.wdata[cc_pkg::POS_FREQ_LSB +: 4])) begin
        freq_q <= bus_req.wdata[cc_pkg::POS_FREQ_LSB +: 4];
      end
      tune_en_q <= bus_req.wdata[cc_pkg::POS_TRIM_ENABLE];
    end
  end

  // reload timer: starts when auto-tune goes from on to off
  always_ff @(posedge clk) begin
    if (rst) begin
      reload_busy_q <= 1'b0;
      reload_cnt_q <= 8'h00;
    end else if (clk_en) begin
      if (wr_hf_ctrl && tune_en_q && !bus_req.wdata[cc_pkg::POS_TRIM_ENABLE]) begin
        reload_busy_q <= 1'b1;
        reload_cnt_q <= 8'(cc_pkg::TRIM_UPDATE_CYC - 1);
      end else if (reload_busy_q) begin
        if (reload_cnt_q == 8'h00) begin
          reload_busy_q <= 1'b0;
        end else begin
          reload_cnt_q <= reload_cnt_q - 8'h01;
        end
      end
    end
  end

  // trim register: only the six low bits are stored
  always_ff @(posedge clk) begin
    if (rst) begin
      trim_q <= cc_pkg::RST_HF_OSC_TRIM[5:0];
    end else if (clk_en) begin
      if (reload_busy_q && reload_cnt_q == 8'h00) begin
        trim_q <= tuner_result;
      end else if (wr_trim) begin
        // bits 7:6 of the write are dropped
        trim_q <= bus_req.wdata[5:0];
      end
    end
  end

  // pll control register
  always_ff @(posedge clk) begin
    if (rst) begin
      pll_rsb_q <= cc_pkg::RST_PLL_CONTROL[cc_pkg::POS_RUN_IN_STANDBY];
      pll_src_q <= cc_pkg::RST_PLL_CONTROL[cc_pkg::POS_PLL_SOURCE];
      mult_q <= cc_pkg::RST_PLL_CONTROL[cc_pkg::POS_MULT_LSB +: 2];
    end else if (clk_en && wr_pll_ctrl) begin
      pll_rsb_q <= bus_req.wdata[cc_pkg::POS_RUN_IN_STANDBY];
      pll_src_q <= bus_req.wdata[cc_pkg::POS_PLL_SOURCE];
      // reserved multiplier leaves the setting as it was
      if (bus_req.wdata[cc_pkg::POS_MULT_LSB +: 2] != cc_pkg::MULT_RESERVED) begin
        mult_q <= bus_req.wdata[cc_pkg::POS_MULT_LSB +: 2];
      end
    end
  end

  // lf oscillator control register
  always_ff @(posedge clk) begin
    if (rst) begin
      lf_rsb_q <= cc_pkg::RST_LF_OSC_CONTROL[cc_pkg::POS_RUN_IN_STANDBY];
    end else if (clk_en && wr_lf_ctrl) begin
      lf_rsb_q <= bus_req.wdata[cc_pkg::POS_RUN_IN_STANDBY];
    end
  end

  // read data, valid the cycle after the read strobe only
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (clk_en) begin
      rdata_q <= 8'h00;
      if (bus_req.rd) begin
        case (bus_req.addr)
          cc_pkg::OFS_MAIN_CLOCK_STATUS: rdata_q <= status_byte;
          cc_pkg::OFS_HF_OSC_CONTROL: begin
            rdata_q <= {hf_rsb_q, 1'b0, freq_q, 1'b0, tune_en_q};
          end
          // sign bit mirrored into the top two bits
          cc_pkg::OFS_HF_OSC_TRIM: begin
            rdata_q <= {{2{trim_q[cc_pkg::POS_TRIM_SIGN]}}, trim_q};
          end
          cc_pkg::OFS_PLL_CONTROL: rdata_q <= {pll_rsb_q, pll_src_q, 4'h0, mult_q};
          cc_pkg::OFS_LF_OSC_CONTROL: rdata_q <= {lf_rsb_q, 7'h00};
          default: rdata_q <= 8'h00;  // unmapped reads zero
        endcase
      end
    end
  end

  // readiness of the source the main clock wants to move to
  always_comb begin
    case (target_q)
      cc_pkg::SRC_INT_HF: target_stable = sync2_q.int_hf_stable;
      cc_pkg::SRC_INT_LF: target_stable = sync2_q.int_lf_stable;
      cc_pkg::SRC_EXT_LF: target_stable = ext_lf_status;
      cc_pkg::SRC_EXT_HF: target_stable = ext_hf_status;
      default: target_stable = 1'b0;
    endcase
  end

  // main clock switch: flag stands until the new source is stable
  always_ff @(posedge clk) begin
    if (rst) begin
      switching_q <= 1'b0;
      target_q <= cc_pkg::SRC_INT_HF;
      mclk_q <= cc_pkg::SRC_INT_HF;
    end else if (clk_en) begin
      if (mclk_switch_req) begin
        // a new request retargets a switch still in progress
        switching_q <= 1'b1;
        target_q <= mclk_switch_src;
      end else if (switching_q && target_stable) begin
        switching_q <= 1'b0;
        mclk_q <= target_q;
      end
    end
  end

  // oscillator run decisions; the main clock counts as a requester
  always_ff @(posedge clk) begin
    if (rst) begin
      hf_run_q <= 1'b0;
      pll_run_q <= 1'b0;
      lf_run_q <= 1'b0;
    end else if (clk_en) begin
      hf_run_q <= keep_running(hf_rsb_q, sleep_mode, 1'b0,
                               clk_req.hf || mclk_q == cc_pkg::SRC_INT_HF ||
                               (switching_q && target_q == cc_pkg::SRC_INT_HF) ||
                               (clk_req.pll && !pll_src_q));
      // a multiplier of zero switches the pll off whatever else is asked
      pll_run_q <= mult_q != cc_pkg::MULT_OFF &&
                   keep_running(pll_rsb_q, sleep_mode, 1'b0, clk_req.pll);
      lf_run_q <= keep_running(lf_rsb_q, sleep_mode, 1'b1,
                               clk_req.lf || mclk_q == cc_pkg::SRC_INT_LF ||
                               (switching_q && target_q == cc_pkg::SRC_INT_LF));
    end
  end

  // hf delivery: request held, oscillator stable, then two of its cycles
  always_ff @(posedge clk) begin
    if (rst) begin
      hf_cnt_q <= 8'h00;
      hf_avail_q <= 1'b0;
    end else if (clk_en) begin
      if (!clk_req.hf || !sync2_q.int_hf_stable) begin
        hf_cnt_q <= 8'h00;
        hf_avail_q <= 1'b0;
      end else if (hf_cnt_q == 8'(cc_pkg::HF_AVAIL_CYC - 1)) begin
        hf_avail_q <= 1'b1;
      end else begin
        hf_cnt_q <= hf_cnt_q + 8'h01;
      end
    end
  end

  // pll delivery also waits for its source to be stable
  always_ff @(posedge clk) begin
    if (rst) begin
      pll_cnt_q <= 8'h00;
      pll_avail_q <= 1'b0;
    end else if (clk_en) begin
      if (!clk_req.pll || !sync2_q.pll_running || mult_q == cc_pkg::MULT_OFF ||
          !(pll_src_q ? ext_hf_status : sync2_q.int_hf_stable)) begin
        pll_cnt_q <= 8'h00;
        pll_avail_q <= 1'b0;
      end else if (pll_cnt_q == 8'(cc_pkg::PLL_AVAIL_CYC - 1)) begin
        pll_avail_q <= 1'b1;
      end else begin
        pll_cnt_q <= pll_cnt_q + 8'h01;
      end
    end
  end

  // lf delivery: four slow cycles, a long count kept as a parameter
  always_ff @(posedge clk) begin
    if (rst) begin
      lf_cnt_q <= 16'h0000;
      lf_avail_q <= 1'b0;
    end else if (clk_en) begin
      if (!clk_req.lf || !sync2_q.int_lf_stable) begin
        lf_cnt_q <= 16'h0000;
        lf_avail_q <= 1'b0;
      end else if (lf_cnt_q == 16'(LF_AVAIL_CYCLES - 1)) begin
        lf_avail_q <= 1'b1;
      end else begin
        lf_cnt_q <= lf_cnt_q + 16'h0001;
      end
    end
  end

  // outputs, all straight from flops
  assign bus_rdata = rdata_q;
  assign hf_osc_run = hf_run_q;
  assign hf_clk_available = hf_avail_q;
  assign hf_frequency_select = freq_q;
  assign crystal_trim_enable = tune_en_q;
  assign hf_trim = trim_q;
  assign pll_run = pll_run_q;
  assign pll_clk_available = pll_avail_q;
  assign pll_source = pll_src_q;
  assign pll_multiplier = mult_q;
  assign lf_osc_run = lf_run_q;
  assign lf_clk_available = lf_avail_q;
  assign mclk_source = mclk_q;
  assign main_clock_switching = switching_q;

endmodule : cc_clock_config

`default_nettype wire

// ===== testbench/cc_clock_config_assertions.sv
/* checker for cc_clock_config: read port, trim, pll, frequency and switch flags.
   assumes it is bound to the design top and that clk_en is high in simulation. */
`default_nettype none
module cc_clock_config_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // inputs seen
  input wire logic clk_en,
  input wire cc_pkg::cc_bus_req_t bus_req,
  input wire logic ccp_unlocked,
  input wire cc_pkg::cc_req_t clk_req,
  input wire logic mclk_switch_req,
  // outputs seen
  input wire logic [7:0] bus_rdata,
  input wire logic [3:0] hf_frequency_select,
  input wire logic crystal_trim_enable,
  input wire logic [5:0] hf_trim,
  input wire logic pll_source,
  input wire logic [1:0] pll_multiplier,
  input wire logic hf_clk_available,
  input wire logic pll_clk_available,
  input wire cc_pkg::cc_src_t mclk_source,
  input wire logic main_clock_switching
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // decoded write strobes; reserved codes must not land
  logic wr_ctl;
  logic wr_pll;
  assign wr_ctl = clk_en && bus_req.wr && bus_req.addr == 8'h08;
  assign wr_pll = clk_en && bus_req.wr && bus_req.addr == 8'h10;
  a_rdata_idle_zero: assert property (clk_en && !bus_req.rd |=> bus_rdata == 8'h00)
    else $error("read data not zero");
  a_trim_sign_mirror: assert property (clk_en && bus_req.rd && bus_req.addr == 8'h09 |=>
    bus_rdata[5:0] == $past(hf_trim) && bus_rdata[7:6] == {2{bus_rdata[5]}})
    else $error("trim read wrong");
  a_trim_locked: assert property (clk_en && crystal_trim_enable |=> $stable(hf_trim))
    else $error("trim moved while locked");
  a_freq_reserved: assert property (wr_ctl && (bus_req.wdata[5:2] == 4'h4 ||
    bus_req.wdata[5:2] > 4'h9) |=> $stable(hf_frequency_select))
    else $error("reserved frequency stored");
  a_pll_write_locked: assert property (wr_pll && !ccp_unlocked |=>
    $stable({pll_source, pll_multiplier}))
    else $error("locked pll write landed");
  a_mult_write: assert property (wr_pll && ccp_unlocked && bus_req.wdata[1:0] != 2'h3 |=>
    pll_multiplier == $past(bus_req.wdata[1:0]) && pll_source == $past(bus_req.wdata[6]))
    else $error("pll write lost");
  a_switch_flag_set: assert property (clk_en && mclk_switch_req |=> main_clock_switching)
    else $error("switch flag not set");
  a_source_after_flag: assert property ($changed(mclk_source) |-> $past(main_clock_switching))
    else $error("source moved without switch");
  a_hf_on_request: assert property (hf_clk_available |-> $past(clk_req.hf))
    else $error("hf given without request");
  a_pll_on_request: assert property (pll_clk_available |-> $past(clk_req.pll))
    else $error("pll given without request");
  a_hf_startup_wait: assert property ($rose(hf_clk_available) |-> $past(clk_req.hf, 8))
    else $error("hf given before start-up");
endmodule // cc_clock_config_assertions
bind cc_clock_config cc_clock_config_assertions i_cc_clock_config_assertions (.clk, .rst,
  .clk_en, .bus_req, .ccp_unlocked, .clk_req, .mclk_switch_req, .bus_rdata,
  .hf_frequency_select, .crystal_trim_enable, .hf_trim, .pll_source, .pll_multiplier,
  .hf_clk_available, .pll_clk_available, .mclk_source, .main_clock_switching);
`default_nettype wire

// ===== testbench/cc_clock_config_tb_top.sv
/* self-checking bench for cc_clock_config: registers, status, switch, availability.
   assumes the package, design and checker are compiled before it. */
`default_nettype none
module cc_clock_config_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LFC = 8; // short lf wait keeps the run brief
  logic clk = 1'b0;
  logic rst = 1'b1;
  cc_pkg::cc_bus_req_t bus_req = '0;
  logic ccp_unlocked = 1'b0;
  logic hf_sel = 1'b0;
  logic lf_sel = 1'b0;
  cc_pkg::cc_osc_raw_t osc_raw = '0;
  cc_pkg::cc_mode_t sleep_mode = cc_pkg::MODE_ACTIVE;
  cc_pkg::cc_req_t clk_req = '0;
  logic sw_req = 1'b0;
  cc_pkg::cc_src_t sw_src = cc_pkg::SRC_INT_HF;
  logic [5:0] tuner = 6'h00;
  // design outputs
  logic [7:0] rdata;
  logic hf_run, hf_av, pll_run, pll_av, lf_run, lf_av, trim_en, pll_src, sw_flag;
  logic [3:0] freq;
  logic [5:0] trim;
  logic [1:0] mult;
  cc_pkg::cc_src_t msrc;
  logic [2:0] av;
  // expected read data, oldest first
  logic [7:0] exp_q[$];
  logic rd_seen = 1'b0;
  logic [31:0] lf_q = 32'h0ECB;
  int failures = 0;
  int n_tests = 0;
  logic [7:0] v, e;
  int k;
  assign av = {hf_av, pll_av, lf_av};
  always #20 clk = ~clk;
  cc_clock_config #(.LF_AVAIL_CYCLES(LFC)) i_cc_clock_config (.clk, .rst, .clk_en(1'b1),
    .bus_req, .bus_rdata(rdata), .ccp_unlocked, .ext_hf_source_select(hf_sel),
    .ext_lf_source_select(lf_sel), .osc_raw, .sleep_mode, .clk_req, .mclk_switch_req(sw_req),
    .mclk_switch_src(sw_src), .tuner_result(tuner), .hf_osc_run(hf_run),
    .hf_clk_available(hf_av), .hf_frequency_select(freq), .crystal_trim_enable(trim_en),
    .hf_trim(trim), .pll_run(pll_run), .pll_clk_available(pll_av), .pll_source(pll_src),
    .pll_multiplier(mult), .lf_osc_run(lf_run), .lf_clk_available(lf_av),
    .mclk_source(msrc), .main_clock_switching(sw_flag));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    n_tests++;
    if (got !== want) begin
      failures++;
      $display("CHECK FAILED %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic report_and_stop;
    if (failures == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // a wait that ran out ends the run at once
  task automatic waited(input logic ok);
    chk({7'h00, ok}, 8'h01);
    if (ok !== 1'b1) report_and_stop();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one-cycle write; unlock rides with the strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic u);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    ccp_unlocked <= u;
    @(posedge clk);
    bus_req <= '0;
    ccp_unlocked <= 1'b0;
  endtask
  // one-cycle read; the monitor compares the data later
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    exp_q.push_back(x);
    @(posedge clk);
    bus_req <= '0;
  endtask
  task automatic sw(input cc_pkg::cc_src_t s);
    sw_src <= s;
    sw_req <= 1'b1;
    @(posedge clk);
    sw_req <= 1'b0;
  endtask
  // request one source, check it is withheld for start-up, then given, then dropped
  task automatic avail(input int i, input int n);
    int j;
    clk_req <= '0;
    cyc(3);
    clk_req[i] <= 1'b1;
    for (j = 0; j < n + 8 && av[i] !== 1'b1; j++) @(posedge clk);
    chk({7'h00, (j >= n - 2)}, 8'h01);
    waited(av[i] === 1'b1);
    clk_req <= '0;
    cyc(3);
    chk({7'h00, av[i]}, 8'h00);
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_seen) chk(rdata, exp_q.pop_front());
    rd_seen <= bus_req.rd;
  end
  // hang guard
  initial begin
    cyc(20000);
    failures++;
    report_and_stop();
  end
  initial begin
    cyc(4);
    rst <= 1'b0;
    rd(8'h08, cc_pkg::RST_HF_OSC_CONTROL);
    rd(8'h09, 8'h00);
    rd(8'h10, 8'h00);
    rd(8'h18, 8'h00);
    rd(8'h33, 8'h00);
    wr(8'h10, 8'hC2, 1'b0);
    rd(8'h10, 8'h00);
    wr(8'h10, 8'hC2, 1'b1);
    cyc(1); // the write edge itself still shows the old field
    chk({7'h00, pll_src}, 8'h01);
    e = 8'hC2;
    for (k = 0; k < 4; k++) begin
      wr(8'h10, {6'h30, k[1:0]}, 1'b1);
      if (k != 3) e = {6'h30, k[1:0]};
      rd(8'h10, e);
      chk({6'h00, mult}, {6'h00, e[1:0]});
    end
    e = 8'h0C;
    for (k = 0; k < 16; k++) begin
      wr(8'h08, {2'b00, k[3:0], 2'b00}, 1'b1);
      if (k != 4 && k < 10) e = {2'b00, k[3:0], 2'b00};
      rd(8'h08, e);
      chk({4'h0, freq}, {4'h0, e[5:2]});
    end
    // both trim limits, then random values with junk in the top bits
    for (k = 0; k < 12; k++) begin
      lf_q = lfsr(lf_q);
      v = (k == 0) ? 8'h60 : (k == 1) ? 8'h9F : lf_q[7:0];
      wr(8'h09, v, 1'b0);
      rd(8'h09, {{2{v[5]}}, v[5:0]});
      chk({2'b00, trim}, {2'b00, v[5:0]});
    end
    tuner <= 6'h2A;
    wr(8'h08, 8'h25, 1'b1);
    wr(8'h09, 8'h05, 1'b0);
    rd(8'h09, {{2{v[5]}}, v[5:0]});
    chk({7'h00, trim_en}, 8'h01);
    wr(8'h08, 8'h24, 1'b1);
    cyc(cc_pkg::TRIM_UPDATE_CYC - 4);
    chk({2'b00, trim}, {2'b00, v[5:0]});
    wr(8'h09, 8'h01, 1'b0);
    cyc(4);
    rd(8'h09, 8'hEA);
    // status bits follow the raw levels and the source selects
    for (k = 0; k < 16; k++) begin
      lf_q = lfsr(lf_q);
      {hf_sel, lf_sel, osc_raw} <= lf_q[8:0];
      cyc(3);
      e = {2'b00, osc_raw.pll_running,
        hf_sel ? osc_raw.ext_hf_clock_running : osc_raw.ext_hf_crystal_stable,
        lf_sel ? osc_raw.ext_lf_clock_running : osc_raw.ext_lf_crystal_stable,
        osc_raw.int_lf_stable, osc_raw.int_hf_stable, 1'b0};
      rd(8'h05, e);
    end
    // switch waits for an unstable target
    osc_raw <= '0;
    cyc(3); // let the cleared levels through the synchroniser first
    sw(cc_pkg::SRC_INT_LF);
    cyc(4);
    chk({6'h00, msrc}, 8'h00);
    rd(8'h05, 8'h01);
    osc_raw <= 7'h7F;
    for (k = 0; k < 20 && sw_flag !== 1'b0; k++) @(posedge clk);
    waited(sw_flag === 1'b0);
    chk({6'h00, msrc}, {6'h00, cc_pkg::SRC_INT_LF});
    avail(2, cc_pkg::HF_AVAIL_CYC);
    avail(1, cc_pkg::PLL_AVAIL_CYC);
    avail(0, LFC);
    wr(8'h08, 8'hA4, 1'b1);
    for (k = 0; k < 4; k++) begin
      sleep_mode <= cc_pkg::cc_mode_t'(k);
      cyc(3);
      chk({7'h00, hf_run}, {7'h00, k != 3});
      chk({7'h00, pll_run}, {7'h00, k != 3});
    end
    wr(8'h08, 8'h24, 1'b1);
    wr(8'h10, 8'h42, 1'b1);
    cyc(3);
    chk({6'h00, hf_run, pll_run}, 8'h00);
    sw(cc_pkg::SRC_INT_HF);
    for (k = 0; k < 20 && (sw_flag !== 1'b0 || msrc !== cc_pkg::SRC_INT_HF); k++) cyc(1);
    waited(sw_flag === 1'b0);
    wr(8'h18, 8'h80, 1'b1);
    cyc(3);
    chk({7'h00, lf_run}, 8'h01);
    rd(8'h18, 8'h80);
    wr(8'h18, 8'h00, 1'b1);
    cyc(3);
    chk({7'h00, lf_run}, 8'h00);
    // external targets, both ready by now
    sw(cc_pkg::SRC_EXT_HF);
    for (k = 0; k < 20 && msrc !== cc_pkg::SRC_EXT_HF; k++) cyc(1);
    waited(sw_flag === 1'b0);
    chk({6'h00, msrc}, {6'h00, cc_pkg::SRC_EXT_HF});
    sw(cc_pkg::SRC_EXT_LF);
    for (k = 0; k < 20 && msrc !== cc_pkg::SRC_EXT_LF; k++) cyc(1);
    waited(sw_flag === 1'b0);
    chk({6'h00, msrc}, {6'h00, cc_pkg::SRC_EXT_LF});
    cyc(4);
    report_and_stop();
  end
endmodule // cc_clock_config_tb_top
`default_nettype wire
